/* tb/bsc_tap_host.sv */
/*
  Test controller model: makes the test clock, walks the port state machine
  and shifts instruction or data words lsb first.
  Assumes the device samples tms/tdi on the test clock rise.
*/
`timescale 1ns/1ps
`default_nettype none
module bsc_tap_host (
  output logic test_clk,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  logic run_reg;
  // ----------------------------------------------------------
  // clock, parked low between frames
  // ----------------------------------------------------------
  // 48 ns period keeps all twelve full scans well inside the hang guard
  initial begin
    test_clk = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    run_reg = 1'b1;
    #3;
    forever begin
      #24;
      if (run_reg || test_clk) test_clk = ~test_clk;
    end
  end
  // one test clock: read tdo, then drive the next tms/tdi
  task automatic clk_bit(input logic t, input logic d, output logic o);
    @(posedge test_clk);
    o = tdo;
    tms <= t;
    tdi <= d;
  endtask
  // five tms high reach reset, then park in idle
  task automatic tap_reset();
    logic o;
    run_reg = 1'b1;
    repeat (5) clk_bit(1'b1, 1'b0, o);
    clk_bit(1'b0, 1'b0, o);
    clk_bit(1'b0, 1'b0, o);
    run_reg = 1'b0;
  endtask
  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [197:0] din,
                      output logic [197:0] dout);
    logic o;
    int i;
    run_reg = 1'b1;
    dout = '0;
    // two idle clocks let the observe synchroniser catch up after a parked clock
    clk_bit(1'b0, 1'b0, o);
    clk_bit(1'b0, 1'b0, o);
    clk_bit(1'b1, 1'b0, o);
    if (ir) clk_bit(1'b1, 1'b0, o);
    clk_bit(1'b0, 1'b0, o);
    clk_bit(1'b0, 1'b0, o);
    for (i = 0; i < n; i++) begin
      clk_bit(i == n - 1, din[i], o);
      if (i > 0) dout[i-1] = o;
    end
    clk_bit(1'b1, 1'b0, o);
    dout[n-1] = o;
    clk_bit(1'b0, 1'b0, o);
    clk_bit(1'b0, 1'b0, o);
    run_reg = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
  Self-checking bench: preload and external test of the chain, then the
  two limit checks on converter channel three.
  Assumes the controller model in bsc_tap_host and a simple analog front end.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bsc_pkg::*;
  localparam logic [159:0] PAT = {5{32'hA5C31E69}};
  localparam logic [9:0] VIN = 10'h133; // input level inside both limits
  logic core_clk = 1'b0, rst_n = 1'b0, test_clk, tms, tdi, tdo, tdo_oe;
  logic [PIN_CELLS-1:0] pin_sense;
  logic cnv_cmp_raw, ana_cmp_raw, cmp_quiet_raw, test_drive_on, dummy_busy, ana_res;
  logic [PIN_CELLS-1:0] pin_drive;
  logic [PORTE_PINS-1:0] pe_value, pe_dir, pe_pull;
  bsc_cnv_t cnv, idle;
  logic [9:0] held_v = 10'h000, lim;
  logic [197:0] so, w;
  int fails = 0, total_checks = 0, cycles = 0, busy_n = 0, s, p, k;

  bsc_chain DUT (.core_clk(core_clk), .rst_n(rst_n), .test_clk(test_clk), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_sense(pin_sense), .cnv_cmp_raw(cnv_cmp_raw),
    .ana_cmp_raw(ana_cmp_raw), .cmp_quiet_raw(cmp_quiet_raw), .test_drive_on(test_drive_on),
    .pin_drive(pin_drive), .pe_value(pe_value), .pe_dir(pe_dir), .pe_pull(pe_pull),
    .cnv(cnv), .dummy_busy(dummy_busy), .analog_cmp_result(ana_res));
  bsc_tap_host host (.test_clk(test_clk), .tms(tms), .tdi(tdi), .tdo(tdo));

  always #50 core_clk = ~core_clk;
  // front end: track while hold low, compare code against held level
  always @(posedge core_clk) begin
    if (!cnv.hold) held_v <= VIN;
    cnv_cmp_raw <= (cnv.dac_code > held_v);
  end
  // dummy conversion length and hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (dummy_busy === 1'b1) busy_n <= busy_n + 1;
    if (cycles == 8000) begin
      fails = fails + 1;
      close_out();
    end
  end

  task automatic check(input logic [197:0] got, input logic [197:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // converter word: channel three only, pins as inputs without pull-up
  function automatic logic [197:0] mk(input logic [9:0] dac, input logic hold,
                                      input logic pre);
    logic [197:0] v;
    v = '0;
    v[POS_CONV_ON] = 1'b1;
    v[POS_DAC_LSB +: DAC_W] = dac;
    v[POS_HOLD] = hold;
    v[POS_CHSEL_LSB +: CHSEL_W] = 8'h08;
    v[POS_PASS] = 1'b1;
    v[POS_PRESET] = pre;
    return v;
  endfunction

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    pin_sense = PAT[157:0];
    cnv_cmp_raw = 1'b0;
    ana_cmp_raw = 1'b1;
    cmp_quiet_raw = 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    idle = '0;
    idle.hold = 1'b1;
    idle.latch_preset_n = 1'b1;
    idle.input_channel_select = 8'h01;
    check(198'(cnv), 198'(idle));
    check(198'({test_drive_on, pin_drive}), 198'(0));
    // bypass after reset delays the word by one bit
    host.tap_reset();
    host.scan(1'b0, 4, 198'(4'hB), so);
    check(198'(so[3:0]), 198'(4'h6));
    host.scan(1'b1, 4, 198'(IR_SAMPLE), so);
    check(198'(so[3:0]), 198'(IR_CAPTURE));
    // preload a pin pattern, capture pin levels and comparator cells
    w = UPD_RESET | 198'(PAT[157:0]);
    host.scan(1'b0, 198, w, so);
    check(198'(so[157:0]), 198'(PAT[157:0]));
    check(198'(so[197:196]), 198'(2'b01));
    host.scan(1'b1, 4, 198'(IR_EXTEST), so);
    repeat (12) @(posedge core_clk);
    check(198'({test_drive_on, pin_drive}), 198'({1'b1, PAT[157:0]}));
    for (k = 0; k < PORTE_PINS; k++) begin
      check(198'({pe_value[k], pe_dir[k], pe_pull[k]}), 198'(w[157-3*k -: 3]));
    end
    check(198'(cnv), 198'(idle));
    // limit checks: preload, external test, then the ten steps
    host.scan(1'b1, 4, 198'(IR_SAMPLE), so);
    host.scan(1'b0, 198, mk(10'h200, 1'b1, 1'b1), so);
    host.scan(1'b1, 4, 198'(IR_EXTEST), so);
    for (s = 2; s <= 11; s++) begin
      p = (s - 2) % 5;
      lim = (s < 7) ? 10'h123 : 10'h143;
      host.scan(1'b0, 198, mk((p == 2 || p == 3) ? lim : 10'h200, p != 0, p != 3), so);
      repeat (12) @(posedge core_clk);
      if (p == 4) check(198'(so[POS_COMP]), 198'(s == 11));
    end
    check(198'(busy_n), 198'(DUMMY_CMPS));
    close_out();
  end
endmodule
`default_nettype wire

/* verilog/bsc_chain.sv */
/*
  Boundary-scan segment with converter test cells: test-port controller and
  198-cell chain on test_clk, converter control and comparator latch on
  core_clk. Assumes pin and comparator levels arrive unsynchronised.
*/
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// three-stage synchroniser, change accepted when stages two and three agree
// ---------------------------------------------------------------
module bsc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg;

  // stage chain and agreement filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q <= (s2_reg & ~(s2_reg ^ s3_reg)) | (q & (s2_reg ^ s3_reg));
    end
  end
endmodule

module bsc_chain (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic test_clk,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [bsc_pkg::PIN_CELLS-1:0] pin_sense,
  input wire logic cnv_cmp_raw,
  input wire logic ana_cmp_raw,
  input wire logic cmp_quiet_raw,
  output logic test_drive_on,
  output logic [bsc_pkg::PIN_CELLS-1:0] pin_drive,
  output logic [bsc_pkg::PORTE_PINS-1:0] pe_value,
  output logic [bsc_pkg::PORTE_PINS-1:0] pe_dir,
  output logic [bsc_pkg::PORTE_PINS-1:0] pe_pull,
  output bsc_pkg::bsc_cnv_t cnv,
  output logic dummy_busy,
  output logic analog_cmp_result
);
  import bsc_pkg::*;

  // ---------------------------------------------------------------
  // test clock domain
  // ---------------------------------------------------------------
  bsc_tap_t tap_reg, tap_next;
  logic [IR_LEN-1:0] ir_sh_reg, ir_reg;
  logic [CHAIN_LEN-1:0] chain_reg, upd_reg, cap_vec;
  logic bypass_reg, upd_tog_reg, extest_reg, bsr_sel;
  logic [OBS_W-1:0] obs_core_reg, obs_tck;

  assign bsr_sel = (ir_reg == IR_EXTEST) || (ir_reg == IR_SAMPLE);

  // test-port state walk; five ones on tms always reach reset
  always_comb begin
    tap_next = tap_reg;
    case (tap_reg)
      TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default: tap_next = TAP_RESET;
    endcase
  end

  always_ff @(posedge test_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_reg <= TAP_RESET;
    end else begin
      tap_reg <= tap_next;
    end
  end

  // instruction path; reset state selects bypass
  always_ff @(posedge test_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_sh_reg <= '0;
      ir_reg <= IR_BYPASS;
    end else if (tap_reg == TAP_RESET) begin
      ir_reg <= IR_BYPASS;
    end else if (tap_reg == TAP_CAP_IR) begin
      ir_sh_reg <= IR_CAPTURE;
    end else if (tap_reg == TAP_SH_IR) begin
      ir_sh_reg <= {tdi, ir_sh_reg[IR_LEN-1:1]};
    end else if (tap_reg == TAP_UPD_IR) begin
      ir_reg <= ir_sh_reg;
    end
  end

  // observed levels from the core side
  bsc_sync #(.W(OBS_W)) u_obs_sync (
    .clk(test_clk),
    .rst_n(rst_n),
    .d(obs_core_reg),
    .q(obs_tck)
  );

  // capture image: control cells read back their update value
  always_comb begin
    cap_vec = upd_reg;
    cap_vec[PIN_CELLS-1:0] = obs_tck[PIN_CELLS-1:0];
    cap_vec[POS_COMP] = obs_tck[OBS_COMP];
    cap_vec[POS_CMP_RESULT] = obs_tck[OBS_ANA];
    cap_vec[POS_CMP_QUIET] = obs_tck[OBS_QUIET];
  end

  // boundary chain: capture, shift toward bit zero, bypass cell
  always_ff @(posedge test_clk or negedge rst_n) begin
    if (!rst_n) begin
      chain_reg <= '0;
      bypass_reg <= 1'b0;
    end else if (tap_reg == TAP_CAP_DR) begin
      chain_reg <= bsr_sel ? cap_vec : chain_reg;
      bypass_reg <= 1'b0;
    end else if (tap_reg == TAP_SH_DR) begin
      if (bsr_sel) begin
        chain_reg <= {tdi, chain_reg[CHAIN_LEN-1:1]};
      end
      bypass_reg <= tdi;
    end
  end

  // update latch with a toggle announcing each new word
  always_ff @(posedge test_clk or negedge rst_n) begin
    if (!rst_n) begin
      upd_reg <= UPD_RESET;
      upd_tog_reg <= 1'b0;
    end else if (tap_reg == TAP_UPD_DR && bsr_sel) begin
      upd_reg <= chain_reg;
      upd_tog_reg <= ~upd_tog_reg;
    end
  end

  // follows the instruction at the same edge; the test clock may stop right after
  always_ff @(posedge test_clk or negedge rst_n) begin
    if (!rst_n) begin
      extest_reg <= 1'b0;
    end else if (tap_reg == TAP_RESET) begin
      extest_reg <= 1'b0;
    end else if (tap_reg == TAP_UPD_IR) begin
      extest_reg <= (ir_sh_reg == IR_EXTEST);
    end
  end

  // serial out on the falling edge, bit zero first
  always_ff @(negedge test_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo_oe <= (tap_reg == TAP_SH_DR) || (tap_reg == TAP_SH_IR);
      if (tap_reg == TAP_SH_IR) begin
        tdo <= ir_sh_reg[0];
      end else begin
        tdo <= bsr_sel ? chain_reg[0] : bypass_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // core clock domain
  // ---------------------------------------------------------------
  logic [1:0] xfer_q;
  logic tog_seen_reg, prev_on_reg, preset_prev_reg, result_reg;
  logic [CHAIN_LEN-1:0] core_upd_reg;
  logic [OBS_W-1:0] raw_vec, raw_q;
  logic [3:0] dummy_cnt_reg;
  bsc_cnv_t cnv_next;

  bsc_sync #(.W(2)) u_ctl_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d({extest_reg, upd_tog_reg}),
    .q(xfer_q)
  );

  assign raw_vec = {cmp_quiet_raw, ana_cmp_raw, cnv_cmp_raw, pin_sense};

  bsc_sync #(.W(OBS_W)) u_pin_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d(raw_vec),
    .q(raw_q)
  );

  // take the update word once its toggle has settled; it is stable by then
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_seen_reg <= 1'b0;
      core_upd_reg <= UPD_RESET;
    end else if (xfer_q[0] != tog_seen_reg) begin
      tog_seen_reg <= xfer_q[0];
      core_upd_reg <= upd_reg;
    end
  end

  // converter controls from the top chain cells, idle values otherwise
  always_comb begin
    cnv_next.converter_on = core_upd_reg[POS_CONV_ON];
    cnv_next.converter_fast_select = core_upd_reg[POS_FAST];
    cnv_next.gain_stage_on = core_upd_reg[POS_GAIN_ON];
    cnv_next.cmp_input_mux_on = core_upd_reg[POS_MUX_ON];
    cnv_next.bandgap_to_cmp_input = core_upd_reg[POS_BANDGAP];
    cnv_next.dac_code = core_upd_reg[POS_DAC_LSB +: DAC_W];
    cnv_next.hold = core_upd_reg[POS_HOLD];
    cnv_next.input_channel_select = core_upd_reg[POS_CHSEL_LSB +: CHSEL_W];
    cnv_next.negative_input_select = core_upd_reg[POS_NEG_LSB +: NEG_W];
    cnv_next.latch_preset_n = core_upd_reg[POS_PRESET];
    if (!xfer_q[1]) begin
      cnv_next = '0;
      cnv_next.hold = UPD_RESET[POS_HOLD];
      cnv_next.latch_preset_n = UPD_RESET[POS_PRESET];
      cnv_next.input_channel_select = UPD_RESET[POS_CHSEL_LSB +: CHSEL_W];
    end
  end

  // pin and converter drive, only under external test
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_drive_on <= 1'b0;
      pin_drive <= '0;
      cnv <= '0;
    end else begin
      test_drive_on <= xfer_q[1];
      // other ports below port E arrive pre-ordered; no port C 2..5 cells
      // port A triplets arrive in chain pin order too
      pin_drive <= xfer_q[1] ? core_upd_reg[PIN_CELLS-1:0] : '0;
      cnv <= cnv_next;
    end
  end

  // per-pin triplet split for port E
  for (genvar k = 0; k < PORTE_PINS; k++) begin : g_porte
    localparam int TOP = PORTE_TOP - CELLS_PER_PIN * k;
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        pe_value[k] <= 1'b0;
        pe_dir[k] <= 1'b0;
        pe_pull[k] <= 1'b0;
      end else begin
        pe_value[k] <= xfer_q[1] & core_upd_reg[TOP-CELL_VALUE];
        pe_dir[k] <= xfer_q[1] & core_upd_reg[TOP-CELL_DIR];
        pe_pull[k] <= xfer_q[1] & core_upd_reg[TOP-CELL_PULL];
      end
    end
  end

  // dummy conversion of ten comparisons after each enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_on_reg <= 1'b0;
      dummy_cnt_reg <= '0;
      dummy_busy <= 1'b0;
    end else begin
      prev_on_reg <= cnv.converter_on;
      if (cnv.converter_on && !prev_on_reg) begin
        dummy_cnt_reg <= DUMMY_CNT_INIT;
        dummy_busy <= 1'b1;
      end else if (dummy_cnt_reg != 4'h0) begin
        dummy_cnt_reg <= dummy_cnt_reg - 4'h1;
        dummy_busy <= (dummy_cnt_reg > 4'h1);
      end
    end
  end

  // comparator latch: first low preset cycle clears, later low cycles with hold high compare,
  // so the result stands before the next scan captures it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      preset_prev_reg <= 1'b1;
      result_reg <= 1'b0;
    end else begin
      preset_prev_reg <= cnv.latch_preset_n;
      if (!cnv.latch_preset_n && preset_prev_reg) begin
        result_reg <= 1'b0;
      end else if (!cnv.latch_preset_n && cnv.hold) begin
        result_reg <= raw_q[OBS_COMP];
      end
    end
  end

  // status back toward the chain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      obs_core_reg <= '0;
      analog_cmp_result <= 1'b0;
    end else begin
      obs_core_reg <= {raw_q[OBS_QUIET], raw_q[OBS_ANA], result_reg, raw_q[PIN_CELLS-1:0]};
      analog_cmp_result <= raw_q[OBS_ANA];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  shift_order_a: assert property (@(posedge test_clk) disable iff (!rst_n)
    (tap_reg == TAP_SH_DR && bsr_sel) |=> chain_reg[CHAIN_LEN-1] == $past(tdi))
    else $error("chain did not shift toward bit zero");
  tap_reset_a: assert property (@(posedge test_clk) disable iff (!rst_n)
    tms [*5] |=> tap_reg == TAP_RESET)
    else $error("five tms ones did not reach reset");
  bypass_cell_a: assert property (@(posedge test_clk) disable iff (!rst_n)
    (tap_reg == TAP_SH_DR && ir_reg == IR_BYPASS) |=> bypass_reg == $past(tdi))
    else $error("bypass cell did not take tdi");
  update_word_a: assert property (@(posedge test_clk) disable iff (!rst_n)
    (tap_reg == TAP_UPD_DR && bsr_sel) |=> upd_reg == $past(chain_reg) && $changed(upd_tog_reg))
    else $error("update latch missed the chain");
  comp_capture_a: assert property (@(posedge test_clk) disable iff (!rst_n)
    (tap_reg == TAP_CAP_DR && bsr_sel) |=> chain_reg[POS_COMP] == $past(obs_tck[OBS_COMP]))
    else $error("comparator cell not captured");
  dac_field_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (test_drive_on && $stable(core_upd_reg) && $past(test_drive_on))
      |-> cnv.dac_code == core_upd_reg[POS_DAC_LSB +: DAC_W] && cnv.hold == core_upd_reg[POS_HOLD])
    else $error("converter code not from chain cells");
  pin_triplet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (test_drive_on && $stable(core_upd_reg))
      |-> pe_value[0] == core_upd_reg[157] && pe_dir[0] == core_upd_reg[156]
        && pe_pull[7] == core_upd_reg[134])
    else $error("port cell triplet misplaced");
  dummy_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(cnv.converter_on) |=> dummy_busy [*8] ##1 dummy_busy ##1 dummy_busy ##1 !dummy_busy)
    else $error("dummy conversion not ten cycles");
  hold_freeze_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cnv.hold && cnv.latch_preset_n) |=> $stable(result_reg))
    else $error("result changed while sampling");
  preset_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(cnv.latch_preset_n) |=> !result_reg)
    else $error("precharge did not clear latch");
  preset_judge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cnv.latch_preset_n && !$fell(cnv.latch_preset_n) && cnv.hold)
      |=> result_reg == $past(raw_q[OBS_COMP]))
    else $error("comparison not latched while precharged");

  extest_load_c: cover property (@(posedge test_clk) disable iff (!rst_n)
    tap_reg == TAP_UPD_DR && ir_reg == IR_EXTEST);
  dummy_run_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(dummy_busy));
  compare_c: cover property (@(posedge core_clk) disable iff (!rst_n)
    $rose(cnv.latch_preset_n) && cnv.hold && raw_q[OBS_COMP]);
  tap_reset_c: cover property (@(posedge test_clk) disable iff (!rst_n)
    $past(tap_reg) == TAP_SEL_IR && tap_reg == TAP_RESET);
endmodule
`default_nettype wire

/* verilog/bsc_chain_fix.sv */
`timescale 1ns/1ps

/* verilog/bsc_pkg.sv */
/*
  Package for the boundary-scan converter chain: chain positions, instruction
  codes, reset values, the test-port state type and the converter carrier.
  Assumes nothing of its surroundings; both clock domains share it.
*/
`default_nettype none
package bsc_pkg;

  // ---------------------------------------------------------------
  // chain geometry
  // ---------------------------------------------------------------
  localparam int CHAIN_LEN = 198;
  localparam int ANA_TOP = 197;
  localparam int ANA_BOT = 158;
  localparam int PIN_CELLS = 158;
  localparam int CELLS_PER_PIN = 3;
  localparam int CELL_VALUE = 0; // offset below the pin's top position
  localparam int CELL_DIR = 1;
  localparam int CELL_PULL = 2;
  localparam int PORTE_TOP = 157;
  localparam int PORTE_PINS = 8;

  // analog cell positions
  localparam int POS_CMP_QUIET = 197;
  localparam int POS_CMP_RESULT = 196;
  localparam int POS_MUX_ON = 195;
  localparam int POS_BANDGAP = 194;
  localparam int POS_COMP = 193;
  localparam int POS_FAST = 190;
  localparam int POS_CONV_ON = 188;
  localparam int POS_GAIN_ON = 187;
  localparam int POS_DAC_LSB = 177;
  localparam int DAC_W = 10;
  localparam int POS_HOLD = 174;
  localparam int POS_CHSEL_LSB = 165;
  localparam int CHSEL_W = 8;
  localparam int POS_NEG_LSB = 162;
  localparam int NEG_W = 3;
  localparam int POS_PASS = 161;
  localparam int POS_PRESET = 160;

  // observe vector layout (pins below, analog status above)
  localparam int OBS_W = PIN_CELLS + 3;
  localparam int OBS_COMP = 158;
  localparam int OBS_ANA = 159;
  localparam int OBS_QUIET = 160;

  // ---------------------------------------------------------------
  // reset values and instructions
  // ---------------------------------------------------------------
  localparam logic [CHAIN_LEN-1:0] UPD_RESET = (198'h1 << POS_HOLD) | (198'h1 << POS_PRESET)
    | (198'h1 << POS_CHSEL_LSB) | (198'h1 << POS_PASS);
  localparam int IR_LEN = 4;
  localparam logic [IR_LEN-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_LEN-1:0] IR_SAMPLE = 4'h2;
  localparam logic [IR_LEN-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
  localparam int DUMMY_CMPS = 10;
  localparam logic [3:0] DUMMY_CNT_INIT = 4'hA;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
    TAP_EX2_IR, TAP_UPD_IR
  } bsc_tap_t;

  typedef struct packed {
    logic converter_on;
    logic converter_fast_select;
    logic gain_stage_on;
    logic cmp_input_mux_on;
    logic bandgap_to_cmp_input;
    logic [DAC_W-1:0] dac_code;
    logic hold;
    logic [CHSEL_W-1:0] input_channel_select;
    logic [NEG_W-1:0] negative_input_select;
    logic latch_preset_n;
  } bsc_cnv_t;

endpackage
`default_nettype wire
